// ===== inc/bfdv_pkg.sv
// Purpose: constants and carriers for the bfd receive validation block
// Assumes: apb with 8-bit byte address, 32-bit data
// Notes: register layouts are the packed structs below
`default_nettype none
package bfdv_pkg;
   // channel types
   localparam logic [15:0] CT_CC_OLD = 16'h0007;
   localparam logic [15:0] CT_CC_NEW = 16'h0022;
   localparam logic [15:0] CT_CV = 16'h0023;
   // minimum pdu lengths in bytes
   localparam logic [7:0] MIN_LEN_PLAIN = 8'h18;
   localparam logic [7:0] MIN_LEN_AUTH = 8'h1a;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SRC_LDISCR = 8'h04;
   localparam logic [7:0] OFF_SRC_RDISCR = 8'h08;
   localparam logic [7:0] OFF_SINK_LDISCR = 8'h0c;
   localparam logic [7:0] OFF_SINK_RDISCR = 8'h10;
   localparam logic [7:0] OFF_SRC_INFO = 8'h14;
   localparam logic [7:0] OFF_SINK_INFO = 8'h18;
   localparam logic [7:0] OFF_STICKY = 8'h1c;
   localparam logic [7:0] OFF_MISS = 8'h20;
   localparam logic [7:0] OFF_CNT0 = 8'h24;
   localparam int NUM_CNT = 4;
   localparam int CNT_RX_SEL = 0;
   localparam int CNT_RX_NONSEL = 1;
   localparam int CNT_TX_SEL = 2;
   localparam int CNT_TX_NONSEL = 3;
   // reset values and write masks
   localparam logic [31:0] CTRL_RST = 32'hff01_0000;
   localparam logic [31:0] CTRL_MASK = 32'hff07_03ff;
   localparam logic [31:0] INFO_SW_MASK = 32'h0000_ff7f;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   // sticky bit positions: failure code minus one, then loss flags
   localparam int STK_W = 8;
   localparam int STK_LOSS_SRC = 6;
   localparam int STK_LOSS_SINK = 7;

   typedef struct packed {
      logic [7:0] length_upper_limit;
      logic [4:0] rsvd1;
      logic [2:0] expected_protocol_version;
      logic [5:0] rsvd0;
      logic rx_error_cpu_copy;
      logic tx_insert_enable;
      logic rx_validate_enable;
      logic rx_sampling_enable;
      logic single_session_mode;
      logic cv_counter_select;
      logic cc_counter_select;
      logic cc_channel_type_select;
      logic cv_processing_enable;
      logic cc_processing_enable;
   } bfdv_ctrl_s;

   typedef struct packed {
      logic [7:0] remote_multiplier;
      logic rsvd1;
      logic [4:0] remote_diagnostic;
      logic [1:0] remote_state;
      logic [7:0] local_multiplier;
      logic rsvd0;
      logic [4:0] local_diagnostic;
      logic [1:0] local_state;
   } bfdv_info_s;

   typedef struct packed {
      logic [15:0] chan_type;
      logic [2:0] version;
      logic [4:0] diag;
      logic [1:0] state;
      logic auth_present;
      logic multipoint;
      logic [7:0] detect_mult;
      logic [7:0] length;
      logic [31:0] your_discr;
   } bfdv_pdu_s;

   typedef struct packed {
      logic [15:0] chan_type;
      logic far_end;
   } bfdv_tx_s;

   typedef struct packed {
      logic [1:0] state;
      logic [4:0] diag;
      logic [7:0] mult;
   } bfdv_txf_s;

   typedef enum logic [2:0] {
      FAIL_NONE = 3'b000,
      FAIL_VERSION = 3'b001,
      FAIL_SHORT = 3'b010,
      FAIL_LONG = 3'b011,
      FAIL_ZERO_MULT = 3'b100,
      FAIL_MULTIPOINT = 3'b101,
      FAIL_DISCR = 3'b110
   } bfdv_fail_e;
endpackage
`default_nettype wire

// ===== logic/bfdv_top.sv
// Purpose: bfd receive validation, session sampling, loss detect, tx field insert
// Assumes: pdus arrive as one-cycle strobes from logic on sys_clk
// Notes: registers over apb, one wait state per transfer
`default_nettype none
module bfdv_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // receive pdus
   input wire logic rx_valid,
   input wire bfdv_pkg::bfdv_pdu_s rx_pdu,
   output logic rx_accept,
   output logic rx_discard,
   output logic rx_cpu_copy,
   output logic rx_far_end,
   // loss controller tick and event
   input wire logic loss_tick,
   output logic continuity_loss,
   // transmit field insertion
   input wire logic tx_valid,
   input wire bfdv_pkg::bfdv_tx_s tx_req,
   output logic tx_out_valid,
   output logic tx_insert,
   output bfdv_pkg::bfdv_txf_s tx_fields
);
   bfdv_pkg::bfdv_ctrl_s ctrl;
   logic [31:0] src_ldiscr, src_rdiscr, sink_ldiscr, sink_rdiscr;
   bfdv_pkg::bfdv_info_s info [2];
   logic [bfdv_pkg::STK_W-1:0] sticky;
   logic [bfdv_pkg::STK_W-1:0] sticky_set;
   logic [bfdv_pkg::STK_W-1:0] sticky_clr;
   logic [7:0] miss [2];
   logic [1:0] loss_hit;
   logic [15:0] cnt [bfdv_pkg::NUM_CNT];
   logic [bfdv_pkg::NUM_CNT-1:0] cnt_inc;
   logic wr_en, rd_hit;
   logic [31:0] rd_val;
   logic is_cc, is_cv, take, hit_src, hit_sink, far_sel, ok;
   logic [7:0] min_len;
   bfdv_pkg::bfdv_fail_e fail;
   logic tx_cc, tx_cv, tx_sink;

   // apb: access phase answered on its second edge
   assign wr_en = psel & penable & pready & pwrite;

   always_comb begin
      rd_hit = 1'b1;
      rd_val = bfdv_pkg::ZERO32;
      case (paddr)
         bfdv_pkg::OFF_CTRL: rd_val = ctrl;
         bfdv_pkg::OFF_SRC_LDISCR: rd_val = src_ldiscr;
         bfdv_pkg::OFF_SRC_RDISCR: rd_val = src_rdiscr;
         bfdv_pkg::OFF_SINK_LDISCR: rd_val = sink_ldiscr;
         bfdv_pkg::OFF_SINK_RDISCR: rd_val = sink_rdiscr;
         bfdv_pkg::OFF_SRC_INFO: rd_val = info[0];
         bfdv_pkg::OFF_SINK_INFO: rd_val = info[1];
         bfdv_pkg::OFF_STICKY: rd_val = {24'h00_0000, sticky};
         bfdv_pkg::OFF_MISS: rd_val = {16'h0000, miss[1], miss[0]};
         bfdv_pkg::OFF_CNT0: rd_val = {16'h0000, cnt[bfdv_pkg::CNT_RX_SEL]};
         bfdv_pkg::OFF_CNT0 + 8'h04: rd_val = {16'h0000, cnt[bfdv_pkg::CNT_RX_NONSEL]};
         bfdv_pkg::OFF_CNT0 + 8'h08: rd_val = {16'h0000, cnt[bfdv_pkg::CNT_TX_SEL]};
         bfdv_pkg::OFF_CNT0 + 8'h0c: rd_val = {16'h0000, cnt[bfdv_pkg::CNT_TX_NONSEL]};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= bfdv_pkg::ZERO32;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~rd_hit;
         prdata <= (psel & penable & ~pready & ~pwrite) ? rd_val : bfdv_pkg::ZERO32;
      end
   end

   // software owned configuration, never touched by hardware
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= bfdv_pkg::CTRL_RST;
         src_ldiscr <= bfdv_pkg::ZERO32;
         src_rdiscr <= bfdv_pkg::ZERO32;
         sink_ldiscr <= bfdv_pkg::ZERO32;
         sink_rdiscr <= bfdv_pkg::ZERO32;
      end else if (wr_en) begin
         case (paddr)
            bfdv_pkg::OFF_CTRL: ctrl <= pwdata & bfdv_pkg::CTRL_MASK;
            bfdv_pkg::OFF_SRC_LDISCR: src_ldiscr <= pwdata;
            bfdv_pkg::OFF_SRC_RDISCR: src_rdiscr <= pwdata;
            bfdv_pkg::OFF_SINK_LDISCR: sink_ldiscr <= pwdata;
            bfdv_pkg::OFF_SINK_RDISCR: sink_rdiscr <= pwdata;
            default: ;
         endcase
      end
   end

   // classification
   always_comb begin
      is_cc = rx_pdu.chan_type == (ctrl.cc_channel_type_select ?
              bfdv_pkg::CT_CC_NEW : bfdv_pkg::CT_CC_OLD);
      is_cv = rx_pdu.chan_type == bfdv_pkg::CT_CV;
      take = rx_valid & ((is_cc & ctrl.cc_processing_enable) |
             (is_cv & ctrl.cv_processing_enable));
      min_len = rx_pdu.auth_present ? bfdv_pkg::MIN_LEN_AUTH : bfdv_pkg::MIN_LEN_PLAIN;
      hit_src = rx_pdu.your_discr == src_ldiscr;
      hit_sink = ~ctrl.single_session_mode & (rx_pdu.your_discr == sink_ldiscr);
   end

   // ordered checks, first failure wins
   always_comb begin
      fail = bfdv_pkg::FAIL_NONE;
      far_sel = 1'b0;
      if (ctrl.rx_validate_enable) begin
         if (rx_pdu.version != ctrl.expected_protocol_version) begin
            fail = bfdv_pkg::FAIL_VERSION;
         end else if (rx_pdu.length < min_len) begin
            fail = bfdv_pkg::FAIL_SHORT;
         end else if (rx_pdu.length > ctrl.length_upper_limit) begin
            fail = bfdv_pkg::FAIL_LONG;
         end else if (rx_pdu.detect_mult == 8'h00) begin
            fail = bfdv_pkg::FAIL_ZERO_MULT;
         end else if (rx_pdu.multipoint) begin
            fail = bfdv_pkg::FAIL_MULTIPOINT;
         end else if (!hit_src && !hit_sink) begin
            fail = bfdv_pkg::FAIL_DISCR;
         end else begin
            far_sel = ~hit_src & hit_sink;
         end
      end
   end
   assign ok = take & (fail == bfdv_pkg::FAIL_NONE);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rx_accept <= 1'b0;
         rx_discard <= 1'b0;
         rx_cpu_copy <= 1'b0;
         rx_far_end <= 1'b0;
      end else begin
         rx_accept <= ok;
         rx_discard <= take & (fail != bfdv_pkg::FAIL_NONE);
         rx_cpu_copy <= take & (fail != bfdv_pkg::FAIL_NONE) & ctrl.rx_error_cpu_copy;
         rx_far_end <= ok & far_sel;
      end
   end

   // session info: local part software, remote part sampled
   genvar s;
   generate
      for (s = 0; s < 2; s++) begin : g_sess
         logic mine, active;
         // independent mode: far-end pdus belong to the sink function
         assign mine = ok & (far_sel == (s == 1));
         // loss is watched by the source alone or the sink alone
         assign active = ctrl.single_session_mode == (s == 0);
         assign loss_hit[s] = loss_tick & active & (info[s].remote_multiplier != 8'h00) &
                              (miss[s] != info[s].remote_multiplier) &
                              (miss[s] + 8'h01 == info[s].remote_multiplier);

         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               info[s] <= bfdv_pkg::ZERO32;
            end else begin
               if (wr_en && paddr == (s == 0 ? bfdv_pkg::OFF_SRC_INFO : bfdv_pkg::OFF_SINK_INFO)) begin
                  info[s] <= (info[s] & ~bfdv_pkg::INFO_SW_MASK) |
                             (pwdata & bfdv_pkg::INFO_SW_MASK);
               end else if (mine && is_cc && ctrl.rx_sampling_enable) begin
                  info[s].remote_state <= rx_pdu.state;
                  info[s].remote_diagnostic <= rx_pdu.diag;
                  info[s].remote_multiplier <= rx_pdu.detect_mult;
               end
            end
         end

         // a valid pdu clears the miss count over a same-cycle tick, which still raises loss_hit
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               miss[s] <= 8'h00;
            end else if (mine) begin
               miss[s] <= 8'h00;
            end else if (loss_tick && active && miss[s] != info[s].remote_multiplier) begin
               miss[s] <= miss[s] + 8'h01;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         continuity_loss <= 1'b0;
      end else begin
         continuity_loss <= |loss_hit;
      end
   end

   // error flags: write one clears, a new set wins over the clear
   always_comb begin
      sticky_set = '0;
      if (take && fail != bfdv_pkg::FAIL_NONE) begin
         sticky_set[fail - 3'b001] = 1'b1;
      end
      sticky_set[bfdv_pkg::STK_LOSS_SRC] = loss_hit[0];
      sticky_set[bfdv_pkg::STK_LOSS_SINK] = loss_hit[1];
      sticky_clr = (wr_en && paddr == bfdv_pkg::OFF_STICKY) ? pwdata[bfdv_pkg::STK_W-1:0] : '0;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sticky <= '0;
      end else begin
         sticky <= (sticky & ~sticky_clr) | sticky_set;
      end
   end

   // transmit side
   always_comb begin
      tx_cc = tx_req.chan_type == (ctrl.cc_channel_type_select ?
              bfdv_pkg::CT_CC_NEW : bfdv_pkg::CT_CC_OLD);
      tx_cv = tx_req.chan_type == bfdv_pkg::CT_CV;
      tx_sink = ~ctrl.single_session_mode & tx_req.far_end;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tx_out_valid <= 1'b0;
         tx_insert <= 1'b0;
         tx_fields <= '0;
      end else begin
         tx_out_valid <= tx_valid;
         tx_insert <= tx_valid & (tx_cc | tx_cv) & ctrl.tx_insert_enable;
         tx_fields <= tx_sink ?
            {info[1].local_state, info[1].local_diagnostic, info[1].local_multiplier} :
            {info[0].local_state, info[0].local_diagnostic, info[0].local_multiplier};
      end
   end

   // counters, wrap silently
   always_comb begin
      cnt_inc = '0;
      cnt_inc[bfdv_pkg::CNT_RX_SEL] = take & ((is_cc & ctrl.cc_counter_select) |
                                      (is_cv & ctrl.cv_counter_select));
      cnt_inc[bfdv_pkg::CNT_RX_NONSEL] = take & ((is_cc & ~ctrl.cc_counter_select) |
                                         (is_cv & ~ctrl.cv_counter_select));
      cnt_inc[bfdv_pkg::CNT_TX_SEL] = tx_valid & ((tx_cc & ctrl.cc_counter_select) |
                                      (tx_cv & ctrl.cv_counter_select));
      cnt_inc[bfdv_pkg::CNT_TX_NONSEL] = tx_valid & ((tx_cc & ~ctrl.cc_counter_select) |
                                         (tx_cv & ~ctrl.cv_counter_select));
   end

   genvar c;
   generate
      for (c = 0; c < bfdv_pkg::NUM_CNT; c++) begin : g_cnt
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               cnt[c] <= 16'h0000;
            end else if (cnt_inc[c]) begin
               cnt[c] <= cnt[c] + 16'h0001;
            end
         end
      end
   endgenerate

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // classification and gating
   AST_CV_GATED: assert property (
      rx_valid && is_cv && !ctrl.cv_processing_enable |=> !rx_accept && !rx_discard)
      else $error("cv pdu handled while disabled");

   AST_UNKNOWN_TYPE: assert property (
      rx_valid && !is_cc && !is_cv |=> !rx_accept && !rx_discard)
      else $error("non-bfd channel type handled");

   AST_RX_COUNT: assert property (
      take && is_cc && ctrl.cc_counter_select
      |=> cnt[bfdv_pkg::CNT_RX_SEL] == $past(cnt[bfdv_pkg::CNT_RX_SEL]) + 16'h0001)
      else $error("selected rx pdu not counted");

   // ordered checks, one reason per frame
   AST_VERSION: assert property (
      take && ctrl.rx_validate_enable && rx_pdu.version != ctrl.expected_protocol_version
      |=> rx_discard && sticky[0])
      else $error("version mismatch not rejected");

   AST_SHORT: assert property (
      take && ctrl.rx_validate_enable && rx_pdu.version == ctrl.expected_protocol_version &&
      rx_pdu.auth_present && rx_pdu.length == 8'h19 |=> rx_discard && sticky[1])
      else $error("short authenticated pdu accepted");

   AST_LONG: assert property (
      rx_accept && $past(ctrl.rx_validate_enable) |->
      $past(rx_pdu.length) <= $past(ctrl.length_upper_limit))
      else $error("long pdu accepted");

   AST_ZERO_MULT: assert property (
      rx_accept |-> $past(rx_pdu.detect_mult) != 8'h00 || !$past(ctrl.rx_validate_enable))
      else $error("zero multiplier accepted");

   AST_MULTIPOINT: assert property (
      rx_accept && $past(ctrl.rx_validate_enable) |-> !$past(rx_pdu.multipoint))
      else $error("multipoint pdu accepted");

   // a version failure must not leave any later reason behind
   AST_ONE_REASON: assert property (
      rx_discard && $past(rx_pdu.version) != $past(ctrl.expected_protocol_version)
      |-> (sticky[5:1] & ~$past(sticky[5:1])) == 5'h00 && !rx_accept)
      else $error("more than one failure reason");

   AST_COPY: assert property (
      rx_cpu_copy |-> rx_discard && $past(ctrl.rx_error_cpu_copy))
      else $error("cpu copy without failure");

   // sessions and sampling
   AST_DISCR: assert property (
      rx_accept && !rx_far_end && $past(ctrl.rx_validate_enable) |->
      $past(rx_pdu.your_discr) == $past(src_ldiscr))
      else $error("near pdu with foreign discriminator");

   AST_FAR: assert property (
      rx_far_end |-> rx_accept && !$past(ctrl.single_session_mode) &&
      $past(rx_pdu.your_discr) == $past(sink_ldiscr))
      else $error("far session pdu misrouted");

   AST_SAMPLE: assert property (
      ok && is_cc && !far_sel && ctrl.rx_sampling_enable && !wr_en
      |=> info[0].remote_state == $past(rx_pdu.state) &&
          info[0].remote_multiplier == $past(rx_pdu.detect_mult))
      else $error("remote fields not sampled");

   AST_SINK_SAMPLE: assert property (
      ok && is_cc && far_sel && ctrl.rx_sampling_enable && !wr_en
      |=> info[1].remote_multiplier == $past(rx_pdu.detect_mult))
      else $error("sink multiplier not sampled");

   AST_LOSS: assert property (
      continuity_loss |-> $past(loss_tick) ##0
      (miss[0] == info[0].remote_multiplier || miss[1] == info[1].remote_multiplier))
      else $error("loss without reaching multiplier");

   // flags and transmit
   AST_STICKY_HOLD: assert property (
      (($past(sticky) & ~sticky) & ~$past(sticky_clr)) == '0)
      else $error("error flag dropped without clear");

   AST_TX_FIELDS: assert property (
      tx_valid && !tx_req.far_end |=> tx_fields.mult == $past(info[0].local_multiplier))
      else $error("source multiplier not inserted");

   // software fields are never written by hardware
   AST_LOCAL_RO: assert property (
      !wr_en |=> $stable(src_ldiscr) && $stable(info[0].local_state))
      else $error("software field changed by hardware");

   AST_SINK_RO: assert property (
      !wr_en |=> $stable(sink_ldiscr) && $stable(info[1].local_multiplier))
      else $error("sink field changed by hardware");

   CV_ACCEPT: cover property (rx_accept && !rx_far_end);
   CV_FAR: cover property (rx_accept && rx_far_end);
   CV_DISCR: cover property (rx_discard && rx_cpu_copy);
   CV_LOSS: cover property (continuity_loss);
   CV_SINK_LOSS: cover property (continuity_loss && !ctrl.single_session_mode);
endmodule // bfdv_top
`default_nettype wire

// ===== verification/bfdv_pipe_model.sv
// Purpose: frame pipeline model feeding received pdus into the block
// Assumes: one pdu per send strobe, sampled on sys_clk
// Notes: idle bus inverts its contents every cycle, so the last pdu reappears on every second idle cycle
`default_nettype none
module bfdv_pipe_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // bench request
   input wire logic send,
   input wire bfdv_pkg::bfdv_pdu_s pdu_in,
   // towards the block
   output logic rx_valid,
   output bfdv_pkg::bfdv_pdu_s rx_pdu
);
   timeunit 1ns;
   timeprecision 1ns;
   // toggling idle data so a sample one cycle late cannot pass for the last frame
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rx_valid <= 1'b0;
         rx_pdu <= '0;
      end else begin
         rx_valid <= send;
         rx_pdu <= send ? pdu_in : ~rx_pdu;
      end
   end
endmodule // bfdv_pipe_model
`default_nettype wire

// ===== verification/tb_bfdv_top.sv
// Purpose: self-checking bench for the bfd receive validation block
// Assumes: apb master with one idle cycle between transfers
// Notes: expected rx and tx results queued by drivers, popped by a monitor
`default_nettype none
module tb_bfdv_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, send, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata, base;
   logic rx_valid, rx_accept, rx_discard, rx_cpu_copy, rx_far_end;
   logic loss_tick, continuity_loss, tx_valid, tx_out_valid, tx_insert;
   bfdv_pkg::bfdv_pdu_s pdu_in, rx_pdu, p;
   bfdv_pkg::bfdv_tx_s tx_req;
   bfdv_pkg::bfdv_txf_s tx_fields;
   logic [3:0] rxq[$];
   logic [15:0] txq[$];
   int n_errors = 0;
   int checks = 0;
   int loss_seen = 0;
   int unsigned seed_v;
   localparam logic [31:0] SRCD = 32'h1111_0001;
   localparam logic [31:0] SNKD = 32'h2222_0002;
   logic [7:0] stk [11] = '{8'h01, 8'h02, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h01,
      8'h00, 8'h00, 8'h00};
   logic [9:0] cb [8] = '{10'h3ef, 10'h3ef, 10'h3ef, 10'h3ef, 10'h3eb, 10'h3eb, 10'h3ee, 10'h3ed};
   logic [15:0] ct [8] = '{16'h0022, 16'h0007, 16'h0023, 16'h0024, 16'h0007, 16'h0022,
      16'h0022, 16'h0023};
   logic ok [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   bfdv_top dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_valid(rx_valid), .rx_pdu(rx_pdu), .rx_accept(rx_accept),
      .rx_discard(rx_discard), .rx_cpu_copy(rx_cpu_copy), .rx_far_end(rx_far_end),
      .loss_tick(loss_tick), .continuity_loss(continuity_loss), .tx_valid(tx_valid),
      .tx_req(tx_req), .tx_out_valid(tx_out_valid), .tx_insert(tx_insert),
      .tx_fields(tx_fields));
   bfdv_pipe_model u_pipe (.sys_clk(sys_clk), .nrst(nrst), .send(send), .pdu_in(pdu_in),
      .rx_valid(rx_valid), .rx_pdu(rx_pdu));

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task conclude();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // outputs sampled before this edge's updates land
   always @(posedge sys_clk) begin
      if (continuity_loss === 1'b1) loss_seen++;
      if ({rx_accept, rx_discard, rx_cpu_copy} !== 3'b000) begin
         if (rxq.size() == 0) chk("rx unexpected", 0, 1);
         else chk("rx result", rxq.pop_front(), {rx_accept, rx_discard, rx_cpu_copy, rx_far_end});
      end
      if (tx_out_valid !== 1'b0) begin
         if (txq.size() == 0) chk("tx unexpected", 0, 1);
         else chk("tx fields", txq.pop_front(), {tx_insert, tx_fields});
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      conclude();
   end

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("apb answer", 1, 0);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rdata);
   endtask

   task cfg(input logic [9:0] b);
      apb(1'b1, bfdv_pkg::OFF_CTRL, {8'h40, 5'h00, 3'h1, 6'h00, b});
   endtask

   task rx(input bfdv_pkg::bfdv_pdu_s q, input logic [3:0] e, input logic expect_out);
      if (expect_out) rxq.push_back(e);
      @(posedge sys_clk);
      send <= 1'b1;
      pdu_in <= q;
      @(posedge sys_clk);
      send <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask

   task tick(input int k);
      repeat (k) begin
         @(posedge sys_clk);
         loss_tick <= 1'b1;
         @(posedge sys_clk);
         loss_tick <= 1'b0;
      end
      repeat (3) @(posedge sys_clk);
   endtask

   task tx(input logic fe, input logic [14:0] f);
      txq.push_back({1'b1, f});
      @(posedge sys_clk);
      tx_valid <= 1'b1;
      tx_req <= {bfdv_pkg::CT_CC_NEW, fe};
      @(posedge sys_clk);
      tx_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   task done(input string s);
      $display("test %s finished", s);
   endtask

   function automatic bfdv_pkg::bfdv_pdu_s good(input logic [31:0] yd, input logic [7:0] dm);
      bfdv_pkg::bfdv_pdu_s g;
      g = '0;
      g.chan_type = bfdv_pkg::CT_CC_NEW;
      g.version = 3'h1;
      g.length = bfdv_pkg::MIN_LEN_PLAIN;
      g.detect_mult = dm;
      g.your_discr = yd;
      g.state = 2'($urandom);
      g.diag = 5'($urandom);
      return g;
   endfunction

   initial begin
      {nrst, psel, penable, pwrite, send, loss_tick, tx_valid} = '0;
      paddr = '0;
      pwdata = '0;
      pdu_in = '0;
      tx_req = '0;
      seed_v = $urandom(32'h0483);
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      rd("ctrl reset", bfdv_pkg::OFF_CTRL, bfdv_pkg::CTRL_RST);
      apb(1'b0, 8'h40, 32'h1234_5678);
      chk("unmapped err", 1, rerr);
      chk("unmapped data", 0, rdata);
      done("reset");
      cfg(10'h3ef);
      apb(1'b1, bfdv_pkg::OFF_SRC_LDISCR, SRCD);
      apb(1'b1, bfdv_pkg::OFF_SINK_LDISCR, SNKD);
      apb(1'b1, bfdv_pkg::OFF_SINK_RDISCR, 32'h4444_0004);
      apb(1'b1, bfdv_pkg::OFF_SRC_INFO, 32'h0000_0a15);
      apb(1'b1, bfdv_pkg::OFF_SINK_INFO, 32'h0000_0526);
      // ordered failures, then length boundaries that must pass
      for (int i = 0; i < 11; i++) begin
         p = good(SRCD, 8'h03);
         case (i)
            0: p.version = 3'h2;
            1: p.length = 8'h17;
            2: {p.auth_present, p.length} = {1'b1, 8'h19};
            3: p.length = 8'h41;
            4: p.detect_mult = 8'h00;
            5: p.multipoint = 1'b1;
            6: p.your_discr = 32'h0000_0009;
            7: {p.version, p.length, p.multipoint} = {3'h0, 8'h00, 1'b1};
            9: {p.auth_present, p.length} = {1'b1, 8'h1a};
            10: p.length = 8'h40;
            default: p.length = 8'h18;
         endcase
         rx(p, (stk[i] != 8'h00) ? 4'b0110 : 4'b1000, 1'b1);
         rd("rx flags", bfdv_pkg::OFF_STICKY, {24'h0, stk[i]});
         apb(1'b1, bfdv_pkg::OFF_STICKY, 32'h0000_00ff);
      end
      p = good(SRCD, 8'h03);
      p.multipoint = 1'b1;
      rx(p, 4'b0110, 1'b1);
      rx(good(SRCD, 8'h03), 4'b1000, 1'b1);
      rd("flag kept", bfdv_pkg::OFF_STICKY, 32'h0000_0010);
      apb(1'b1, bfdv_pkg::OFF_STICKY, 32'h0000_0010);
      rd("flag cleared", bfdv_pkg::OFF_STICKY, 32'h0);
      cfg(10'h16f);
      p = good(SRCD, 8'h03);
      p.version = 3'h2;
      rx(p, 4'b1000, 1'b1);
      cfg(10'h1ef);
      rx(p, 4'b0100, 1'b1);
      apb(1'b1, bfdv_pkg::OFF_STICKY, 32'h0000_00ff);
      done("validation");
      for (int j = 0; j < 8; j++) begin
         cfg(cb[j]);
         p = good(SRCD, 8'h03);
         p.chan_type = ct[j];
         rx(p, 4'b1000, ok[j]);
      end
      chk("missing rx", 0, 32'(rxq.size()));
      done("channel types");
      cfg(10'h3ef);
      p = good(SRCD, 8'(1 + $urandom % 200));
      rx(p, 4'b1000, 1'b1);
      rd("src info", bfdv_pkg::OFF_SRC_INFO, {p.detect_mult, 1'b0, p.diag, p.state, 16'h0a15});
      cfg(10'h3cf);
      p = good(SNKD, 8'h03);
      rx(p, 4'b1001, 1'b1);
      rd("sink info", bfdv_pkg::OFF_SINK_INFO, {8'h03, 1'b0, p.diag, p.state, 16'h0526});
      done("sampling");
      tick(2);
      chk("loss early", 0, loss_seen);
      tick(1);
      chk("loss sink", 1, loss_seen);
      rd("loss sink flag", bfdv_pkg::OFF_STICKY, 32'h0000_0080);
      apb(1'b1, bfdv_pkg::OFF_STICKY, 32'h0000_00ff);
      cfg(10'h3ef);
      rx(good(SRCD, 8'h02), 4'b1000, 1'b1);
      tick(2);
      chk("loss src", 2, loss_seen);
      rd("loss src flag", bfdv_pkg::OFF_STICKY, 32'h0000_0040);
      done("loss");
      cfg(10'h3cf);
      apb(1'b0, bfdv_pkg::OFF_CNT0 + 8'(4 * bfdv_pkg::CNT_TX_SEL), 32'h0);
      base = rdata;
      tx(1'b0, {2'b01, 5'h05, 8'h0a});
      tx(1'b1, {2'b10, 5'h09, 8'h05});
      rd("tx sel count", bfdv_pkg::OFF_CNT0 + 8'(4 * bfdv_pkg::CNT_TX_SEL), base + 2);
      rd("src discr", bfdv_pkg::OFF_SRC_LDISCR, SRCD);
      rd("sink discr", bfdv_pkg::OFF_SINK_RDISCR, 32'h4444_0004);
      chk("missing tx", 0, 32'(txq.size()));
      done("transmit");
      conclude();
   end
endmodule // tb_bfdv_top
`default_nettype wire
